/* verilog/dacs_channel_state.sv */
// Per-channel address, count and collision status state of an eight-channel DMA controller
// Behaviour
// RULE1 - Primary base per channel, writable, resets zero
// RULE2 - Alternate base per channel, writable, resets zero
// RULE3 - Peripheral target per channel, writable, resets zero
// RULE4 - Software avoids rewriting target/total while enabled
// RULE5 - Ten-bit total, upper six bits read zero
// RULE6 - Block moves programmed total plus one
// RULE7 - Peripheral collision flags in bits 15..8
// RULE8 - Buffer collision flags in bits 7..0
// RULE9 - Direction set: RAM read, peripheral written
// RULE10 - Ping-pong select bit shows active base
// RULE11 - Step modes: increment, fixed, peripheral, reserved
// RULE12 - Same-cycle same-address writes set flag; software clears
// RULE13 - RAM address is base plus scaled offset
`timescale 1ns/1ps

module dacs_channel_state
   import dacs_pkg::*;
#(
   parameter int CHANNELS = DACS_CHANNELS
)
(
   input wire logic sys_clk,                  // System clock, 200 MHz
   input wire logic reset_n,                  // Synchronous reset, active low
   input wire logic clk_en,                   // Freezes all state while low
   input wire logic [7:0] reg_addr,           // Register index
   input wire logic [15:0] reg_wdata,         // Write data
   input wire logic reg_wr,                   // Write strobe
   input wire logic reg_rd,                   // Read strobe
   output logic [15:0] reg_rdata,             // Read data, cycle after the strobe
   input wire logic xfer_req,                 // Engine asks for one element
   input wire logic [2:0] xfer_chan,          // Channel of the request
   input wire logic [15:0] periph_offset,     // Offset supplied by the peripheral
   input wire dacs_probe_t cpu_ram_wr,        // Processor write into DMA RAM
   input wire dacs_probe_t cpu_periph_wr,     // Processor write into a peripheral
   output dacs_xfer_t xfer,                   // Issued transfer
   output logic [7:0] pingpong_buffer_select, // Active base per channel
   output logic irq                           // Unmasked collision pending
);

   // ************************************************************
   // Storage
   // ************************************************************
   logic [15:0] primary_base_address [CHANNELS];   // Primary bases
   logic [15:0] alternate_base_address [CHANNELS]; // Alternate bases
   logic [15:0] periph_target [CHANNELS];          // Peripheral targets
   logic [9:0] transfer_total [CHANNELS];          // Programmed totals
   logic [15:0] control [CHANNELS];                // Channel control words
   logic [9:0] elem_offset [CHANNELS];             // Running element offset
   logic [15:0] collision_flags;                   // Sticky collision flags
   logic [15:0] irq_mask;                          // Interrupt mask

   // Register index split into channel and slot
   function automatic logic [2:0] idx_chan(input logic [7:0] a);
      idx_chan = a[5:3];
   endfunction

   function automatic logic [2:0] idx_slot(input logic [7:0] a);
      idx_slot = a[2:0];
   endfunction

   // ************************************************************
   // Decode
   // ************************************************************
   wire chan_space = (reg_addr < DACS_GLOBAL_BASE);           // Per-channel window
   wire [2:0] w_chan = idx_chan(reg_addr);                    // Addressed channel
   wire [2:0] w_slot = idx_slot(reg_addr);                    // Addressed slot
   wire wr_chan = reg_wr && chan_space;                       // Channel register write
   wire wr_flags = reg_wr && (reg_addr == DACS_REG_COLLISION); // Flag clear write
   wire wr_mask = reg_wr && (reg_addr == DACS_REG_IRQ_MASK);   // Mask write

   // Read selection
   logic [15:0] chan_rdata;
   always_comb
   begin
      case (w_slot)
         DACS_SLOT_PRIMARY: chan_rdata = primary_base_address[w_chan];     // RULE1
         DACS_SLOT_ALTERNATE: chan_rdata = alternate_base_address[w_chan]; // RULE2
         DACS_SLOT_TARGET: chan_rdata = periph_target[w_chan];             // RULE3
         DACS_SLOT_TOTAL: chan_rdata = {6'h00, transfer_total[w_chan]};    // RULE5
         DACS_SLOT_CONTROL: chan_rdata = control[w_chan];
         default: chan_rdata = 16'h0000;                                   // Unused slot
      endcase
   end

   logic [15:0] next_rdata;
   always_comb
   begin
      if (chan_space)
         next_rdata = chan_rdata;
      else if (reg_addr == DACS_REG_COLLISION)
         next_rdata = collision_flags;
      else if (reg_addr == DACS_REG_PINGPONG)
         next_rdata = {8'h00, pingpong_buffer_select};
      else if (reg_addr == DACS_REG_IRQ_MASK)
         next_rdata = irq_mask;
      else
         next_rdata = 16'h0000;                  // Unmapped reads as zero
   end

   // ************************************************************
   // Transfer address generation
   // ************************************************************
   wire [15:0] sel_ctl = control[xfer_chan];                          // Requesting channel control
   wire sel_enable = sel_ctl[DACS_CTL_ENABLE];                       // Channel enabled
   wire sel_byte = sel_ctl[DACS_CTL_SIZE];                           // Element size
   wire sel_dir = sel_ctl[DACS_CTL_DIR];                             // Direction
   wire [1:0] sel_mode = sel_ctl[DACS_CTL_MODE_HI:DACS_CTL_MODE_LO]; // Step mode
   wire sel_pingpong = sel_ctl[DACS_CTL_PINGPONG];                   // Ping-pong enabled
   wire take = xfer_req && sel_enable;                               // Request accepted

   // Base picked by the ping-pong state
   wire [15:0] sel_base = pingpong_buffer_select[xfer_chan] ?
                          alternate_base_address[xfer_chan] : primary_base_address[xfer_chan]; // RULE10

   wire [9:0] sel_offset = elem_offset[xfer_chan];                   // Running offset
   wire [15:0] inc_offset = sel_byte ? {6'h00, sel_offset} : {5'h00, sel_offset, 1'b0}; // RULE13

   logic [15:0] ram_addr;
   always_comb
   begin
      case (sel_mode)
         DACS_STEP_POSTINC: ram_addr = 16'(sel_base + inc_offset);    // RULE11 RULE13
         DACS_STEP_FIXED: ram_addr = sel_base;                        // RULE11
         DACS_STEP_PERIPH: ram_addr = 16'(sel_base + periph_offset);  // RULE11
         default: ram_addr = sel_base;          // Reserved mode: no stepping
      endcase
   end

   // Block ends after total + 1 elements
   wire last_elem = (sel_offset == transfer_total[xfer_chan]); // RULE6

   // ************************************************************
   // Collision detection
   // ************************************************************
   // A hit needs the channel writing that side in the very cycle of the processor write
   wire hit_ram = take && !sel_dir && cpu_ram_wr.valid && (cpu_ram_wr.addr == ram_addr);   // RULE12 RULE8
   wire hit_periph = take && sel_dir && cpu_periph_wr.valid &&
                     (cpu_periph_wr.addr == periph_target[xfer_chan]);                     // RULE12 RULE7

   logic [15:0] set_flags;
   always_comb
   begin
      set_flags = 16'h0000;
      set_flags[DACS_PERIPH_FLAG_LSB + 32'(xfer_chan)] = hit_periph; // RULE7
      set_flags[DACS_BUFFER_FLAG_LSB + 32'(xfer_chan)] = hit_ram;    // RULE8
   end

   wire [15:0] clr_flags = wr_flags ? reg_wdata : 16'h0000;         // Write one to clear
   // Set beats a clear in the same cycle so no event is lost
   wire [15:0] next_flags = (collision_flags & ~clr_flags) | set_flags; // RULE12

   // ************************************************************
   // Channel registers
   // ************************************************************
   // Software writes; the target and total are not guarded while the channel runs,
   // so software must keep off them then
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < CHANNELS; i++)
         begin
            primary_base_address[i] <= DACS_RESET_VALUE;   // RULE1
            alternate_base_address[i] <= DACS_RESET_VALUE; // RULE2
            periph_target[i] <= DACS_RESET_VALUE;          // RULE3
            transfer_total[i] <= 10'h000;                  // RULE5
            control[i] <= DACS_RESET_VALUE;
         end
      end
      else if (clk_en && wr_chan)
      begin
         case (w_slot)
            DACS_SLOT_PRIMARY: primary_base_address[w_chan] <= reg_wdata;     // RULE1
            DACS_SLOT_ALTERNATE: alternate_base_address[w_chan] <= reg_wdata; // RULE2
            DACS_SLOT_TARGET: periph_target[w_chan] <= reg_wdata;             // RULE3 RULE4
            DACS_SLOT_TOTAL: transfer_total[w_chan] <= reg_wdata[9:0];        // RULE5 RULE4
            DACS_SLOT_CONTROL: control[w_chan] <= reg_wdata & DACS_CTL_MASK;
            default: ;                                                        // Unused slot ignored
         endcase
      end
   end

   // ************************************************************
   // Element offset and ping-pong state
   // ************************************************************
   // Offset restarts at block end; ping-pong flips base only when enabled
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < CHANNELS; i++)
            elem_offset[i] <= 10'h000;
         pingpong_buffer_select <= 8'h00;
      end
      else if (clk_en)
      begin
         // Clearing enable rewinds the channel so a restart begins at the primary base
         for (int i = 0; i < CHANNELS; i++)
         begin
            if (!control[i][DACS_CTL_ENABLE])
            begin
               elem_offset[i] <= 10'h000;
               pingpong_buffer_select[i] <= 1'b0;
            end
         end
         if (take)
         begin
            if (last_elem)
            begin
               elem_offset[xfer_chan] <= 10'h000;                            // RULE6
               if (sel_pingpong)
                  pingpong_buffer_select[xfer_chan] <= !pingpong_buffer_select[xfer_chan]; // RULE10
            end
            else
               elem_offset[xfer_chan] <= 10'(sel_offset + 10'h001);          // RULE6
         end
      end
   end

   // ************************************************************
   // Transfer output
   // ************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         xfer <= '0;
      else if (clk_en)
      begin
         xfer.valid <= take;
         xfer.chan <= xfer_chan;
         xfer.ram_addr <= ram_addr;                 // RULE13
         xfer.periph_addr <= periph_target[xfer_chan]; // RULE3
         xfer.ram_write <= !sel_dir;                // RULE9
         xfer.periph_write <= sel_dir;              // RULE9
         xfer.byte_size <= sel_byte;
         xfer.block_done <= take && last_elem;      // RULE6
      end
   end

   // ************************************************************
   // Status, mask, interrupt and read port
   // ************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         collision_flags <= DACS_RESET_VALUE;       // RULE7 RULE8
         irq_mask <= DACS_RESET_VALUE;
         irq <= 1'b0;
         reg_rdata <= 16'h0000;
      end
      else if (clk_en)
      begin
         collision_flags <= next_flags;             // RULE12
         if (wr_mask)
            irq_mask <= reg_wdata;
         // Uses the next flag value so the line follows the flags with no extra lag
         irq <= |(next_flags & (wr_mask ? reg_wdata : irq_mask));
         reg_rdata <= reg_rd ? next_rdata : 16'h0000;
      end
   end

endmodule

/* shared/dacs_pkg.sv */
// Package of constants and carrier types for the DMA channel address, count and status block
package dacs_pkg;

   // ************************************************************
   // Geometry
   // ************************************************************
   localparam int DACS_CHANNELS = 8;          // Number of channels
   localparam int DACS_CHAN_BITS = 3;         // Channel number width
   localparam int DACS_ADDR_BITS = 8;         // Register index width
   localparam int DACS_DATA_BITS = 16;        // Register data width
   localparam int DACS_COUNT_BITS = 10;       // Implemented transfer count bits

   // ************************************************************
   // Register index map: per channel at chan*8 + slot
   // ************************************************************
   localparam logic [2:0] DACS_SLOT_PRIMARY = 3'h0;    // Primary base address
   localparam logic [2:0] DACS_SLOT_ALTERNATE = 3'h1;  // Alternate base address
   localparam logic [2:0] DACS_SLOT_TARGET = 3'h2;     // Peripheral target address
   localparam logic [2:0] DACS_SLOT_TOTAL = 3'h3;      // Transfer total
   localparam logic [2:0] DACS_SLOT_CONTROL = 3'h4;    // Channel control
   localparam logic [7:0] DACS_GLOBAL_BASE = 8'h40;    // First shared register
   localparam logic [7:0] DACS_REG_COLLISION = 8'h40;  // Collision flags, write one to clear
   localparam logic [7:0] DACS_REG_PINGPONG = 8'h41;   // Ping-pong buffer select, read only
   localparam logic [7:0] DACS_REG_IRQ_MASK = 8'h42;   // Interrupt mask

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int DACS_CTL_ENABLE = 15;       // channel_enable
   localparam int DACS_CTL_SIZE = 14;         // 1 = byte, 0 = word
   localparam int DACS_CTL_DIR = 13;          // 1 = RAM to peripheral
   localparam int DACS_CTL_MODE_HI = 5;       // address_step_mode upper bit
   localparam int DACS_CTL_MODE_LO = 4;       // address_step_mode lower bit
   localparam int DACS_CTL_PINGPONG = 1;      // Ping-pong enable
   localparam logic [15:0] DACS_CTL_MASK = 16'he032;    // Implemented control bits
   localparam logic [15:0] DACS_TOTAL_MASK = 16'h03ff;  // Implemented total bits
   localparam logic [15:0] DACS_RESET_VALUE = 16'h0000; // All registers reset to zero
   localparam int DACS_PERIPH_FLAG_LSB = 8;   // Peripheral collision flags start
   localparam int DACS_BUFFER_FLAG_LSB = 0;   // Buffer collision flags start

   // ************************************************************
   // Modes
   // ************************************************************
   typedef enum logic [1:0] {
      DACS_STEP_POSTINC = 2'b00,              // Advance after each transfer
      DACS_STEP_FIXED = 2'b01,                // Address stays put
      DACS_STEP_PERIPH = 2'b10,               // Offset comes from the peripheral
      DACS_STEP_RESERVED = 2'b11              // Reserved, treated as fixed
   } dacs_step_t;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic valid;                            // One-cycle transfer issue
      logic [2:0] chan;                       // Channel that moved the element
      logic [15:0] ram_addr;                  // DMA RAM address used
      logic [15:0] periph_addr;               // Peripheral register address used
      logic ram_write;                        // 1 = RAM written, peripheral read
      logic periph_write;                     // 1 = peripheral written, RAM read
      logic byte_size;                        // 1 = byte element
      logic block_done;                       // Last element of the block
   } dacs_xfer_t;

   typedef struct packed {
      logic valid;                            // Processor write this cycle
      logic [15:0] addr;                      // Address written
   } dacs_probe_t;

endpackage

/* testbench/dacs_state_props.sv */
// Checker of register answers, transfer issue and interrupt behaviour at the block's ports
`timescale 1ns/1ps
module dacs_state_props
   import dacs_pkg::*;
#(
   parameter int CHANNELS = DACS_CHANNELS
)
(
   input wire logic sys_clk,                      // System clock
   input wire logic reset_n,                      // Synchronous reset, active low
   input wire logic clk_en,                       // Run enable
   input wire logic [7:0] reg_addr,               // Register index
   input wire logic reg_wr,                       // Write strobe
   input wire logic reg_rd,                       // Read strobe
   input wire logic [15:0] reg_rdata,             // Read data
   input wire logic xfer_req,                     // Element request
   input wire dacs_xfer_t xfer,                   // Issued transfer
   input wire logic [7:0] pingpong_buffer_select, // Active base per channel
   input wire logic irq                           // Collision interrupt
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   // ************************************************************
   // Sequences
   // ************************************************************
   // Something that may raise the interrupt: an element or a mask write
   sequence s_irq_cause;
      $past(xfer_req) || $past(xfer_req, 2) || $past(reg_wr) || $past(reg_wr, 2);
   endsequence
   // Two quiet cycles with the interrupt up and no software write
   sequence s_irq_quiet;
      irq && !reg_wr ##1 irq && !reg_wr;
   endsequence

   // ************************************************************
   // Properties
   // ************************************************************
   property p_rdata_idle;
      clk_en && !reg_rd |=> reg_rdata == 16'h0000;
   endproperty
   property p_total_high;
      clk_en && reg_rd && reg_addr < 8'h40 && reg_addr[2:0] == 3'h3 |=> reg_rdata[15:10] == 6'h00;
   endproperty
   property p_hole_zero;
      clk_en && reg_rd && (reg_addr > 8'h42 || (reg_addr < 8'h40 && reg_addr[2:0] > 3'h4)) |=> reg_rdata == 16'h0000;
   endproperty
   property p_valid_cause;
      xfer.valid |-> $past(xfer_req) && $past(clk_en);
   endproperty
   property p_dir_split;
      xfer.valid |-> xfer.ram_write != xfer.periph_write;
   endproperty
   property p_done_valid;
      xfer.block_done |-> xfer.valid;
   endproperty
   property p_select_cause;
      !$stable(pingpong_buffer_select) |-> xfer.valid || $past(xfer.valid) || $past(reg_wr) || $past(reg_wr, 2);
   endproperty
   property p_irq_rise;
      $rose(irq) |-> s_irq_cause;
   endproperty
   property p_irq_hold;
      s_irq_quiet |=> irq;
   endproperty

   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside a read");
   a_total_high: assert property (p_total_high) else $error("transfer total upper bits not zero");
   a_hole_zero: assert property (p_hole_zero) else $error("unmapped index read not zero");
   a_valid_cause: assert property (p_valid_cause) else $error("transfer issued without request");
   a_dir_split: assert property (p_dir_split) else $error("transfer writes both or neither side");
   a_done_valid: assert property (p_done_valid) else $error("block end without transfer");
   a_select_cause: assert property (p_select_cause) else $error("buffer select moved by itself");
   a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without cause");
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped without software clear");
endmodule

/* testbench/dacs_far_side.sv */
// Far-side model: transfer engine requests and processor writes that may collide
`timescale 1ns/1ps
module dacs_far_side
   import dacs_pkg::*;
(
   input wire logic sys_clk,            // System clock
   output logic xfer_req,               // Element request
   output logic [2:0] xfer_chan,        // Requesting channel
   output logic [15:0] periph_offset,   // Offset from the peripheral
   output dacs_probe_t cpu_ram_wr,      // Processor write into DMA RAM
   output dacs_probe_t cpu_periph_wr    // Processor write into a peripheral
);
   // Quiet at time zero
   initial
   begin
      xfer_req = 1'b0;
      xfer_chan = 3'h0;
      periph_offset = 16'h0000;
      cpu_ram_wr = '0;
      cpu_periph_wr = '0;
   end

   // Back-to-back requests; kind 1 or 2 adds a processor write on the first element
   task automatic run(input logic [2:0] ch, input int n, input logic [15:0] off, input logic [1:0] kind,
                      input logic [15:0] a);
      for (int i = 0; i < n; i++)
      begin
         @(posedge sys_clk);
         xfer_req <= 1'b1;
         xfer_chan <= ch;
         periph_offset <= off;
         cpu_ram_wr <= '{kind == 2'h1 && i == 0, a};
         cpu_periph_wr <= '{kind == 2'h2 && i == 0, a};
      end
      @(posedge sys_clk);
      // Released lines show inverted values so stale data never matches by luck
      xfer_req <= 1'b0;
      periph_offset <= ~off;
      cpu_ram_wr <= '{1'b0, ~a};
      cpu_periph_wr <= '{1'b0, ~a};
   endtask
endmodule

/* testbench/test_dacs_channel_state.sv */
// Self-checking testbench of the DMA channel address, count and collision block
`timescale 1ns/1ps
module test_dacs_channel_state;
   import dacs_pkg::*;
   logic sys_clk, reset_n, clk_en, reg_wr, reg_rd, xfer_req, irq;
   logic [7:0] reg_addr, pingpong_buffer_select;
   logic [15:0] reg_wdata, reg_rdata, periph_offset;
   logic [2:0] xfer_chan;
   dacs_probe_t cpu_ram_wr, cpu_periph_wr;
   dacs_xfer_t xfer;
   dacs_xfer_t got_q[$];
   int n_fail = 0;
   int samples_checked = 0;

   dacs_channel_state dacs_channel_state_i (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .xfer_req(xfer_req), .xfer_chan(xfer_chan), .periph_offset(periph_offset), .cpu_ram_wr(cpu_ram_wr),
      .cpu_periph_wr(cpu_periph_wr), .xfer(xfer), .pingpong_buffer_select(pingpong_buffer_select), .irq(irq));
   dacs_far_side dacs_far_side_i (.sys_clk(sys_clk), .xfer_req(xfer_req), .xfer_chan(xfer_chan),
      .periph_offset(periph_offset), .cpu_ram_wr(cpu_ram_wr), .cpu_periph_wr(cpu_periph_wr));

   // Clock at 200 MHz
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // Mid-cycle capture avoids racing the edge that launches a transfer
   always @(negedge sys_clk)
   begin
      if (xfer.valid === 1'b1)
         got_q.push_back(xfer);
   end

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [7:0] ix(input int ch, input int slot);
      return 8'(ch * 8 + slot);
   endfunction
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", e, reg_rdata);
   endtask
   task automatic go(input logic [2:0] ch, input int n, input logic [15:0] off, input logic [1:0] k,
                     input logic [15:0] a);
      dacs_far_side_i.run(ch, n, off, k, a);
      repeat (2) @(negedge sys_clk);
   endtask
   // Pops one captured transfer and checks address, block end and direction
   task automatic take(input logic [15:0] ra, input logic dn, input logic pw);
      dacs_xfer_t x;
      if (got_q.size() == 0)
      begin
         chk("xfer_count", 16'h0001, 16'h0000);
         return;
      end
      x = got_q.pop_front();
      chk("ram_addr", ra, x.ram_addr);
      chk("block_done", {15'h0000, dn}, {15'h0000, x.block_done});
      chk("periph_write", {15'h0000, pw}, {15'h0000, x.periph_write});
      chk("ram_write", {15'h0000, !pw}, {15'h0000, x.ram_write});
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset_values();
      for (int s = 0; s < 4; s++)
      begin
         rd(ix(0, s), 16'h0000);
         rd(ix(7, s), 16'h0000);
      end
      rd(8'h40, 16'h0000);
   endtask
   task automatic t_regs();
      wr(ix(3, 0), 16'hA5C3);
      wr(ix(3, 1), 16'h5A3C);
      wr(ix(3, 2), 16'hFFFF);
      wr(ix(3, 3), 16'hFFFF);
      wr(8'h47, 16'hFFFF);
      wr(8'h41, 16'hFFFF);
      rd(ix(3, 0), 16'hA5C3);
      rd(ix(3, 1), 16'h5A3C);
      rd(ix(3, 2), 16'hFFFF);
      rd(ix(3, 3), 16'h03FF);
      rd(8'h47, 16'h0000);
      rd(8'h41, 16'h0000);
      // A write while the clock enable is low must not land
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(ix(6, 0), 16'h1234);
      clk_en <= 1'b1;
      rd(ix(6, 0), 16'h0000);
   endtask
   task automatic t_block();
      wr(ix(1, 0), 16'h0100);
      wr(ix(1, 3), 16'h0002);
      go(3'h1, 1, 16'h0000, 2'h0, 16'h0000);
      chk("refused_count", 16'h0000, 16'(got_q.size()));
      wr(ix(1, 4), 16'h8000);
      go(3'h1, 3, 16'h0000, 2'h0, 16'h0000);
      take(16'h0100, 1'b0, 1'b0);
      take(16'h0102, 1'b0, 1'b0);
      take(16'h0104, 1'b1, 1'b0);
      wr(ix(1, 4), 16'h0000);
   endtask
   task automatic t_modes();
      logic [15:0] e0 [4] = '{16'h0400, 16'h0400, 16'h0430, 16'h0400};
      logic [15:0] e1 [4] = '{16'h0401, 16'h0400, 16'h0430, 16'h0400};
      wr(ix(5, 0), 16'h0400);
      wr(ix(5, 3), 16'h0001);
      for (int m = 0; m < 4; m++)
      begin
         wr(ix(5, 4), 16'hE000 | 16'(m << 4));
         go(3'h5, 2, 16'h0030, 2'h0, 16'h0000);
         take(e0[m], 1'b0, 1'b1);
         take(e1[m], 1'b1, 1'b1);
         wr(ix(5, 4), 16'h0000);
      end
   endtask
   task automatic t_pingpong();
      wr(ix(2, 0), 16'h0200);
      wr(ix(2, 1), 16'h0300);
      wr(ix(2, 4), 16'h8002);
      go(3'h2, 1, 16'h0000, 2'h0, 16'h0000);
      take(16'h0200, 1'b1, 1'b0);
      rd(8'h41, 16'h0004);
      chk("pingpong", 16'h0004, {8'h00, pingpong_buffer_select});
      go(3'h2, 1, 16'h0000, 2'h0, 16'h0000);
      take(16'h0300, 1'b1, 1'b0);
      rd(8'h41, 16'h0000);
      wr(ix(2, 4), 16'h0000);
   endtask
   task automatic t_collide();
      wr(8'h42, 16'h0000);
      wr(ix(1, 0), 16'h0800);
      wr(ix(1, 3), 16'h0000);
      wr(ix(1, 4), 16'h8010);
      go(3'h1, 1, 16'h0000, 2'h1, 16'h0800);
      take(16'h0800, 1'b1, 1'b0);
      rd(8'h40, 16'h0002);
      chk("irq_masked", 16'h0000, {15'h0000, irq});
      wr(8'h42, 16'h0002);
      rd(8'h40, 16'h0002);
      chk("irq", 16'h0001, {15'h0000, irq});
      wr(ix(4, 2), 16'h0F20);
      wr(ix(4, 4), 16'hA010);
      go(3'h4, 1, 16'h0000, 2'h2, 16'h0F21);
      go(3'h4, 1, 16'h0000, 2'h2, 16'h0F20);
      rd(8'h40, 16'h1002);
      wr(8'h40, 16'h0002);
      rd(8'h40, 16'h1000);
      chk("irq_cleared", 16'h0000, {15'h0000, irq});
      wr(8'h40, 16'h1000);
      rd(8'h40, 16'h0000);
      wr(ix(1, 4), 16'h0000);
      wr(ix(4, 4), 16'h0000);
      got_q.delete();
   endtask

   task automatic results();
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Watchdog: the tests need well under a thousand cycles
   initial
   begin
      #50000;
      n_fail++;
      results();
   end

   // Main sequence
   initial
   begin
      reset_n = 1'b0;
      clk_en = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_reset_values();
      t_regs();
      t_block();
      t_modes();
      t_pingpong();
      t_collide();
      results();
   end
endmodule

bind dacs_channel_state dacs_state_props #(.CHANNELS(CHANNELS)) dacs_state_props_i (.sys_clk(sys_clk),
   .reset_n(reset_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .xfer_req(xfer_req), .xfer(xfer), .pingpong_buffer_select(pingpong_buffer_select),
   .irq(irq));
